// file: hdl/flag_bank.sv
// Sticky flags that hardware sets and software clears
`timescale 1ns/10ps
module flag_bank #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] q_o
);
    // ----------------------------------------
    // One flag per bit, set wins over clear
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            logic next_q;
            always_comb begin
                next_q = set_i[i] | (q_o[i] & ~clr_i[i]);
            end
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    q_o[i] <= RST[i];
                end else begin
                    q_o[i] <= next_q;
                end
            end
        end
    endgenerate
endmodule

// file: hdl/rx_condition.sv
// Receive line polarity and falling edge detection
`timescale 1ns/10ps
module rx_condition (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic rx_i,
    input wire logic invert_i,
    output logic rx_o,
    output logic fall_o
);
    logic next_rx;
    logic next_fall;
    // ----------------------------------------
    // Idle is high after correction
    // ----------------------------------------
    always_comb begin
        next_rx = rx_i ^ invert_i;
        next_fall = rx_o & ~next_rx;
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_o <= 1'b1;
            fall_o <= 1'b0;
        end else begin
            rx_o <= next_rx;
            fall_o <= next_fall;
        end
    end
endmodule

// file: hdl/uart_cfg_flags.sv
// Serial port line control, error flags, enables and buffer status
`timescale 1ns/10ps
module uart_cfg_flags (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [uart_cfg_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rx_i,
    input wire logic tx_data_i,
    input wire uart_cfg_pkg::rx_ev_s rx_ev_i,
    input wire uart_cfg_pkg::tx_ev_s tx_ev_i,
    input wire uart_cfg_pkg::misc_ev_s misc_ev_i,
    input wire uart_cfg_pkg::buf_st_s buf_i,
    output logic rx_o,
    output logic tx_o,
    output uart_cfg_pkg::cfg_s cfg_o,
    output logic peripheral_interrupt_request_o
);
    import uart_cfg_pkg::*;

    logic [7:0] line_control, next_line_control;
    logic [7:0] error_enables, next_error_enables;
    logic abd_done_enable, next_abd_done_enable;
    logic stpmd, next_stpmd;
    logic [3:0] mode, next_mode;
    logic wake_up_enable, next_wake_up_enable;
    logic tx_shift_empty_flag, next_tx_shift_empty_flag;
    logic [7:0] sticky, sticky_set, sticky_clr;
    logic rx_fall;
    logic is_lin, is_dali, is_dmx, is_par;
    logic parity_flag, framing_flag;
    logic wr, access, mapped;
    logic [7:0] err_view, rdata;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_tx, next_irq;
    cfg_s next_cfg;

    // ----------------------------------------
    // Receive line conditioning
    // ----------------------------------------
    rx_condition u_rx (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .rx_i(rx_i),
        .invert_i(line_control[LC_RECEIVE_POLARITY]),
        .rx_o(rx_o),
        .fall_o(rx_fall)
    );

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    always_comb begin
        is_lin = (mode == MODE_LIN_MASTER) || (mode == MODE_LIN_SLAVE);
        is_dali = (mode == MODE_DALI_DEV) || (mode == MODE_DALI_GEAR);
        is_dmx = (mode == MODE_DMX);
        is_par = (mode == MODE_PAR_ODD) || (mode == MODE_PAR_EVEN);
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    always_comb begin
        access = psel_i & penable_i;
        wr = access & pwrite_i & pready_o;
        case (paddr_i)
            OFS_LINE, OFS_ERRF, OFS_ERRE, OFS_GINT, OFS_BUF, OFS_CTRL: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Head-of-buffer status flags
    // ----------------------------------------
    always_comb begin
        parity_flag = 1'b0;
        if (is_lin || is_par) begin
            parity_flag = rx_ev_i.head_parity & ~buf_i.rxbe;
        end else if (mode == MODE_DALI_DEV) begin
            parity_flag = rx_ev_i.head_forward & ~buf_i.rxbe;
        end else if (mode == MODE_ADDR) begin
            parity_flag = rx_ev_i.head_address & ~buf_i.rxbe;
        end
        framing_flag = rx_ev_i.head_frame & ~buf_i.rxbe;
        err_view = {tx_shift_empty_flag, parity_flag, sticky[SK_AUTOBAUD_OVERFLOW_FLAG], sticky[SK_CSUM],
                    framing_flag, sticky[SK_BRK], sticky[SK_OVF], sticky[SK_COLL]};
    end

    // ----------------------------------------
    // Sticky event flags
    // ----------------------------------------
    always_comb begin
        sticky_set = 8'h00;
        sticky_clr = 8'h00;
        sticky_set[SK_COLL] = rx_ev_i.word_done && (rx_ev_i.tx_word != rx_ev_i.rx_word);
        sticky_set[SK_OVF] = rx_ev_i.char_done & rx_ev_i.fifo_full;
        sticky_set[SK_BRK] = rx_ev_i.brk;
        sticky_set[SK_TX_WRITE_ERROR] = (tx_ev_i.write & tx_ev_i.fifo_full)
            | ((mode == MODE_LIN_MASTER) & tx_ev_i.param_write & tx_ev_i.master_active);
        sticky_set[SK_CSUM] = (is_lin & misc_ev_i.csum_err) | (is_dali & misc_ev_i.dali_stop);
        sticky_set[SK_AUTOBAUD_OVERFLOW_FLAG] = is_dali ? misc_ev_i.meas_ovf : misc_ev_i.brg_ovf;
        sticky_set[SK_ABD] = misc_ev_i.abd_done;
        sticky_set[SK_WAKE] = wake_up_enable & rx_fall;
        if (wr) begin
            case (paddr_i)
                OFS_ERRF: begin
                    sticky_clr[SK_AUTOBAUD_OVERFLOW_FLAG] = ~pwdata_i[5];
                    sticky_clr[SK_CSUM] = ~pwdata_i[4];
                    sticky_clr[SK_BRK] = ~pwdata_i[2];
                    sticky_clr[SK_OVF] = ~pwdata_i[1];
                    sticky_clr[SK_COLL] = ~pwdata_i[0];
                end
                OFS_GINT: begin
                    sticky_clr[SK_WAKE] = ~pwdata_i[7];
                    sticky_clr[SK_ABD] = ~pwdata_i[6];
                end
                OFS_BUF: begin
                    sticky_clr[SK_TX_WRITE_ERROR] = ~pwdata_i[7];
                end
                default: begin
                    sticky_clr = 8'h00;
                end
            endcase
        end
    end

    flag_bank #(
        .W(8),
        .RST(STICKY_RST)
    ) u_flags (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .set_i(sticky_set),
        .clr_i(sticky_clr),
        .q_o(sticky)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_comb begin
        next_line_control = line_control;
        next_error_enables = error_enables;
        next_abd_done_enable = abd_done_enable;
        next_stpmd = stpmd;
        next_mode = mode;
        next_wake_up_enable = wake_up_enable;
        if (wr) begin
            case (paddr_i)
                OFS_LINE: next_line_control = pwdata_i[7:0];
                OFS_ERRE: next_error_enables = pwdata_i[7:0];
                OFS_GINT: next_abd_done_enable = pwdata_i[GI_AUTOBAUD_DONE_ENABLE];
                OFS_BUF: next_stpmd = pwdata_i[BS_STPMD];
                OFS_CTRL: begin
                    next_mode = pwdata_i[3:0];
                    next_wake_up_enable = pwdata_i[CT_WUE];
                end
                default: next_mode = mode;
            endcase
        end
        if (wake_up_enable & rx_fall) begin
            next_wake_up_enable = 1'b0;
        end
        next_tx_shift_empty_flag = tx_shift_empty_flag;
        if (tx_ev_i.stop_done) begin
            next_tx_shift_empty_flag = 1'b1;
        end else if (tx_ev_i.shift_active) begin
            next_tx_shift_empty_flag = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            line_control <= LINE_RST;
            error_enables <= 8'h00;
            abd_done_enable <= 1'b0;
            stpmd <= 1'b0;
            mode <= 4'h0;
            wake_up_enable <= 1'b0;
            tx_shift_empty_flag <= TXMT_RST;
        end else begin
            line_control <= next_line_control;
            error_enables <= next_error_enables;
            abd_done_enable <= next_abd_done_enable;
            stpmd <= next_stpmd;
            mode <= next_mode;
            wake_up_enable <= next_wake_up_enable;
            tx_shift_empty_flag <= next_tx_shift_empty_flag;
        end
    end

    // ----------------------------------------
    // Framer configuration and outputs
    // ----------------------------------------
    always_comb begin
        next_cfg.mode = mode;
        next_cfg.rx_halt = sticky[SK_OVF] & ~line_control[LC_RUN];
        next_cfg.tx_stop = line_control[LC_STP+:2];
        next_cfg.rx_two_stop = (line_control[LC_STP+:2] == STP_TWO_BOTH) & (is_dmx | is_dali);
        next_cfg.csum_pid = is_lin & line_control[LC_CSUM];
        next_cfg.csum_acc = ~is_lin & line_control[LC_CSUM];
        next_cfg.sw_flow = (line_control[LC_FLO+:2] == FLO_SW);
        next_cfg.hw_flow = (line_control[LC_FLO+:2] == FLO_HW);
        next_cfg.stpmd = stpmd;
        next_tx = tx_data_i ^ line_control[LC_TRANSMIT_POLARITY];
        next_irq = (|(err_view & error_enables)) | sticky[SK_WAKE]
            | (sticky[SK_ABD] & abd_done_enable);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_o <= '0;
            tx_o <= 1'b1;
            peripheral_interrupt_request_o <= 1'b0;
        end else begin
            cfg_o <= next_cfg;
            tx_o <= next_tx;
            peripheral_interrupt_request_o <= next_irq;
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always_comb begin
        case (paddr_i)
            OFS_LINE: rdata = line_control;
            OFS_ERRF: rdata = err_view;
            OFS_ERRE: rdata = error_enables;
            OFS_GINT: rdata = {sticky[SK_WAKE], sticky[SK_ABD], 3'b000, abd_done_enable, 2'b00};
            OFS_BUF: rdata = {sticky[SK_TX_WRITE_ERROR], stpmd, buf_i.txbe, buf_i.txbf,
                              buf_i.rxidl, buf_i.xon, buf_i.rxbe, buf_i.rxbf};
            OFS_CTRL: rdata = {3'b000, wake_up_enable, mode};
            default: rdata = 8'h00;
        endcase
        next_pready = access & ~pready_o;
        next_pslverr = access & ~pready_o & ~mapped;
        next_prdata = prdata_o;
        if (access & ~pready_o & ~pwrite_i) begin
            next_prdata = {24'h000000, rdata};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_wake_edge;
        wake_up_enable && rx_fall;
    endsequence
    sequence s_wake_done;
        sticky[SK_WAKE] && !wake_up_enable ##1 peripheral_interrupt_request_o;
    endsequence

    property p_wake;
        @(posedge mclk_i) disable iff (rst_i) s_wake_edge |=> s_wake_done;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not raise request");

    property p_tx_empty;
        @(posedge mclk_i) disable iff (rst_i) tx_ev_i.stop_done |=> tx_shift_empty_flag;
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("shift empty not set");

    property p_tx_busy;
        @(posedge mclk_i) disable iff (rst_i)
            tx_ev_i.shift_active && !tx_ev_i.stop_done |=> !tx_shift_empty_flag;
    endproperty
    a_tx_busy: assert property (p_tx_busy) else $error("shift empty while sending");

    property p_tx_pol;
        @(posedge mclk_i) disable iff (rst_i) 1'b1 |=> tx_o == ($past(tx_data_i) ^ $past(line_control[LC_TRANSMIT_POLARITY]));
    endproperty
    a_tx_pol: assert property (p_tx_pol) else $error("transmit polarity wrong");

    property p_overflow;
        @(posedge mclk_i) disable iff (rst_i) rx_ev_i.char_done && rx_ev_i.fifo_full |=> sticky[SK_OVF];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag missed");

    property p_halt;
        @(posedge mclk_i) disable iff (rst_i)
            sticky[SK_OVF] && !line_control[LC_RUN] |=> cfg_o.rx_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("receiver not halted");

    property p_collision;
        @(posedge mclk_i) disable iff (rst_i)
            rx_ev_i.word_done && rx_ev_i.tx_word != rx_ev_i.rx_word |=> sticky[SK_COLL];
    endproperty
    a_collision: assert property (p_collision) else $error("collision flag missed");

    property p_write_err;
        @(posedge mclk_i) disable iff (rst_i) tx_ev_i.write && tx_ev_i.fifo_full |=> sticky[SK_TX_WRITE_ERROR];
    endproperty
    a_write_err: assert property (p_write_err) else $error("write error missed");

    property p_set_wins;
        @(posedge mclk_i) disable iff (rst_i) rx_ev_i.brk && sticky_clr[SK_BRK] |=> sticky[SK_BRK] [*2];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

    property p_masked;
        @(posedge mclk_i) disable iff (rst_i)
            (err_view & error_enables) == 8'h00 && !sticky[SK_WAKE] && !(sticky[SK_ABD] && abd_done_enable)
            |=> !peripheral_interrupt_request_o;
    endproperty
    a_masked: assert property (p_masked) else $error("request without enabled flag");

    property p_apb;
        @(posedge mclk_i) disable iff (rst_i) access && !pready_o |=> pready_o ##1 !pready_o;
    endproperty
    a_apb: assert property (p_apb) else $error("bus answer timing wrong");
endmodule

// file: hdl/uart_cfg_pkg.sv
// Constants, field layout and carrier types of the serial port control block
// Notes on behaviour
// - With run-during-overflow set, receiver keeps syncing after overflow; else it halts.
// - Receive polarity set inverts RX so the idle level is low.
// - Stop field: 00 one, 01 one and half, 1x two; 10 checks both.
// - All modes send chosen stops; only DMX and DALI receivers check two.
// - In LIN, checksum mode 1 adds identifier to sum; 0 leaves it out.
// - Outside LIN, checksum mode 1 accumulates all characters; 0 disables it.
// - Transmit polarity set inverts all output data, TX idles low.
// - Flow field: 00 none, 01 software, 10 hardware handshake, 11 reserved.
// - Shift empty flag sets at end of stop, clears while sending, resets 1.
// - In LIN and parity modes, parity flag shows head byte parity error.
// - Parity flag shows forward frame in DALI device, address in address mode.
// - Auto-baud overflow: measurement counter in DALI, baud generator otherwise.
// - Checksum/stop flag: checksum error in LIN, stop bit detected in DALI.
// - Framing flag shows head receive byte framing error.
// - Break detected on receive line sets break flag.
// - Character arriving with receive FIFO full sets overflow flag.
// - Transmitted word differing from word received meanwhile sets collision flag.
// - Each error flag has enable at same position gating the request.
// - With wake-up enabled, RX idle-to-active sets wake flag and request.
// - Auto-baud done sets flag; requests only when its enable is set.
// - LIN master: identifier write during active master process sets write error.
// - Transmit write while transmit FIFO full sets write error, every mode.
// - Wake-up waits for falling RX, sets wake flag and clears its enable, then raises request.
package uart_cfg_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_LINE = 8'h00;
    localparam logic [7:0] OFS_ERRF = 8'h04;
    localparam logic [7:0] OFS_ERRE = 8'h08;
    localparam logic [7:0] OFS_GINT = 8'h0c;
    localparam logic [7:0] OFS_BUF = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int LC_RUN = 7;
    localparam int LC_RECEIVE_POLARITY = 6;
    localparam int LC_STP = 4;
    localparam int LC_CSUM = 3;
    localparam int LC_TRANSMIT_POLARITY = 2;
    localparam int LC_FLO = 0;
    localparam int GI_AUTOBAUD_DONE_ENABLE = 2;
    localparam int BS_STPMD = 6;
    localparam int CT_WUE = 4;
    localparam int SK_COLL = 0;
    localparam int SK_OVF = 1;
    localparam int SK_BRK = 2;
    localparam int SK_TX_WRITE_ERROR = 3;
    localparam int SK_CSUM = 4;
    localparam int SK_AUTOBAUD_OVERFLOW_FLAG = 5;
    localparam int SK_ABD = 6;
    localparam int SK_WAKE = 7;
    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic [7:0] LINE_RST = 8'h00;
    localparam logic [7:0] STICKY_RST = 8'h00;
    localparam logic TXMT_RST = 1'b1;
    localparam logic [3:0] MODE_ADDR = 4'h4;
    localparam logic [3:0] MODE_PAR_ODD = 4'h2;
    localparam logic [3:0] MODE_PAR_EVEN = 4'h3;
    localparam logic [3:0] MODE_DALI_DEV = 4'h8;
    localparam logic [3:0] MODE_DALI_GEAR = 4'h9;
    localparam logic [3:0] MODE_DMX = 4'ha;
    localparam logic [3:0] MODE_LIN_SLAVE = 4'hb;
    localparam logic [3:0] MODE_LIN_MASTER = 4'hc;
    localparam logic [1:0] STP_TWO_BOTH = 2'b10;
    localparam logic [1:0] FLO_SW = 2'b01;
    localparam logic [1:0] FLO_HW = 2'b10;
    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    typedef struct packed {
        logic char_done;
        logic fifo_full;
        logic brk;
        logic word_done;
        logic [8:0] tx_word;
        logic [8:0] rx_word;
        logic head_parity;
        logic head_frame;
        logic head_forward;
        logic head_address;
    } rx_ev_s;
    typedef struct packed {
        logic shift_active;
        logic stop_done;
        logic write;
        logic fifo_full;
        logic param_write;
        logic master_active;
    } tx_ev_s;
    typedef struct packed {
        logic abd_done;
        logic brg_ovf;
        logic meas_ovf;
        logic csum_err;
        logic dali_stop;
    } misc_ev_s;
    typedef struct packed {
        logic txbe;
        logic txbf;
        logic rxidl;
        logic xon;
        logic rxbe;
        logic rxbf;
    } buf_st_s;
    typedef struct packed {
        logic [3:0] mode;
        logic rx_halt;
        logic [1:0] tx_stop;
        logic rx_two_stop;
        logic csum_pid;
        logic csum_acc;
        logic sw_flow;
        logic hw_flow;
        logic stpmd;
    } cfg_s;
endpackage

// file: sim/serial_node.sv
// Remote serial node driving the receive line
`timescale 1ns/10ps
module serial_node (
    input wire logic mclk_i,
    input wire logic invert_i,
    input wire logic send_i,
    output logic line_o
);
    logic [3:0] left = 4'h0;
    always @(posedge mclk_i) begin
        left <= send_i ? 4'h8 : left - 4'(left != 4'h0);
    end
    assign line_o = (left == 4'h0) ^ invert_i;
endmodule

// file: sim/uart_cfg_flags_tb.sv
// Self-checking bench of the serial port control block
`timescale 1ns/10ps
module uart_cfg_flags_tb;
    import uart_cfg_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [31:0] x; logic e;} row_s;
    logic mclk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata_o, rd;
    logic pready_o, pslverr_o, rx_line, rx_o, tx_o, irq, err, tx_data = 1'b1, send = 1'b0, rx_inv = 1'b0;
    rx_ev_s rx_ev = '0;
    tx_ev_s tx_ev = '0;
    misc_ev_s misc_ev = '0;
    buf_st_s bufs = 6'b101110;
    cfg_s cfg_o;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    row_s rows [5] = '{'{OFS_LINE, 8'had, 32'had, 1'b0}, '{OFS_ERRE, 8'h7f, 32'h7f, 1'b0},
        '{OFS_GINT, 8'hff, 32'h04, 1'b0}, '{OFS_BUF, 8'hff, 32'h6e, 1'b0}, '{8'h18, 8'hff, 32'h0, 1'b1}};

    uart_cfg_flags i_uart_cfg_flags (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .rx_i(rx_line), .tx_data_i(tx_data), .rx_ev_i(rx_ev), .tx_ev_i(tx_ev),
        .misc_ev_i(misc_ev), .buf_i(bufs), .rx_o(rx_o), .tx_o(tx_o), .cfg_o(cfg_o),
        .peripheral_interrupt_request_o(irq));
    serial_node i_serial_node (.mclk_i(mclk_i), .invert_i(rx_inv), .send_i(send), .line_o(rx_line));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i iff pready_o === 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        check(name, rd, exp);
    endtask

    task automatic pulse(input rx_ev_s r, input tx_ev_s t, input misc_ev_s m);
        @(posedge mclk_i);
        rx_ev <= r;
        tx_ev <= t;
        misc_ev <= m;
        @(posedge mclk_i);
        rx_ev <= '0;
        tx_ev <= '{shift_active: t.shift_active, default: 1'b0};
        misc_ev <= '0;
        repeat (2) @(posedge mclk_i);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            complete_run;
        end
    end

    initial begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        check("rx_o", {31'h0, rx_o}, 32'h1);
        rdchk("error_flags", OFS_ERRF, 32'h80);
        rdchk("line_control", OFS_LINE, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            rdchk("readback", rows[i].a, rows[i].x);
            check("slverr", {31'h0, err}, {31'h0, rows[i].e});
        end
        check("tx_stop", {30'h0, cfg_o.tx_stop}, 32'h2);
        check("csum_acc", {31'h0, cfg_o.csum_acc}, 32'h1);
        check("sw_flow", {31'h0, cfg_o.sw_flow}, 32'h1);
        check("tx_o", {31'h0, tx_o}, 32'h0);
        $display("register test done");
        apb(1'b1, OFS_LINE, 8'h44);
        rx_inv <= 1'b1;
        repeat (3) @(posedge mclk_i);
        check("rx_o", {31'h0, rx_o}, 32'h1);
        check("tx_o", {31'h0, tx_o}, 32'h0);
        $display("polarity test done");
        apb(1'b1, OFS_CTRL, 8'h0c);
        pulse('{char_done: 1'b1, fifo_full: 1'b1, brk: 1'b1, word_done: 1'b1, tx_word: 9'h055,
            rx_word: 9'h054, default: 1'b0}, '{shift_active: 1'b1, write: 1'b1, fifo_full: 1'b1,
            default: 1'b0}, '1);
        rdchk("error_flags", OFS_ERRF, 32'h37);
        rdchk("general_interrupt", OFS_GINT, 32'h44);
        rdchk("buffer_status", OFS_BUF, 32'hee);
        check("rx_halt", {31'h0, cfg_o.rx_halt}, 32'h1);
        check("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, OFS_ERRF, 8'h00);
        apb(1'b1, OFS_GINT, 8'h04);
        apb(1'b1, OFS_BUF, 8'h40);
        pulse('0, '{stop_done: 1'b1, default: 1'b0}, '0);
        rdchk("error_flags", OFS_ERRF, 32'h80);
        rdchk("buffer_status", OFS_BUF, 32'h6e);
        check("irq", {31'h0, irq}, 32'h0);
        $display("event test done");
        fork
            apb(1'b1, OFS_ERRF, 8'h00);
            begin
                repeat (3) @(posedge mclk_i);
                rx_ev <= '{brk: 1'b1, default: '0};
                @(posedge mclk_i);
                rx_ev <= '0;
            end
        join
        rdchk("error_flags", OFS_ERRF, 32'h84);
        apb(1'b1, OFS_ERRF, 8'h00);
        rdchk("error_flags", OFS_ERRF, 32'h80);
        $display("clear test done");
        apb(1'b1, OFS_CTRL, 8'h1c);
        @(posedge mclk_i);
        send <= 1'b1;
        @(posedge mclk_i);
        send <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rdchk("general_interrupt", OFS_GINT, 32'h84);
        rdchk("control", OFS_CTRL, 32'h0c);
        check("irq", {31'h0, irq}, 32'h1);
        $display("wake test done");
        apb(1'b1, OFS_CTRL, 8'h0a);
        apb(1'b1, OFS_LINE, 8'h6a);
        repeat (2) @(posedge mclk_i);
        check("rx_two_stop", {31'h0, cfg_o.rx_two_stop}, 32'h1);
        check("hw_flow", {31'h0, cfg_o.hw_flow}, 32'h1);
        check("csum_pid", {31'h0, cfg_o.csum_pid}, 32'h0);
        check("tx_o", {31'h0, tx_o}, 32'h1);
        check("mode", {27'h0, cfg_o.stpmd, cfg_o.mode}, 32'h1a);
        apb(1'b1, OFS_CTRL, 8'h0c);
        repeat (2) @(posedge mclk_i);
        check("rx_two_stop", {31'h0, cfg_o.rx_two_stop}, 32'h0);
        check("csum_pid", {31'h0, cfg_o.csum_pid}, 32'h1);
        pulse('0, '{param_write: 1'b1, master_active: 1'b1, default: 1'b0}, '0);
        rdchk("buffer_status", OFS_BUF, 32'hee);
        rx_ev <= '{head_parity: 1'b1, head_frame: 1'b1, default: '0};
        bufs <= 6'b101100;
        rdchk("error_flags", OFS_ERRF, 32'hc8);
        apb(1'b1, OFS_CTRL, 8'h08);
        rdchk("error_flags", OFS_ERRF, 32'h88);
        $display("mode test done");
        rx_ev <= '0;
        bufs <= 6'b101110;
        rx_inv <= 1'b0;
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        check("irq", {31'h0, irq}, 32'h0);
        check("tx_o", {31'h0, tx_o}, 32'h1);
        rdchk("error_flags", OFS_ERRF, 32'h80);
        rdchk("control", OFS_CTRL, 32'h0);
        $display("restart test done");
        complete_run;
    end
endmodule
